// ===== hw/gpio_clock_select_and_resync.v
`timescale 1ns/1ps
`include "clk_sel_consts.vh"
`default_nettype none
module gpio_clock_select_and_resync (
  input wire mclk,
  input wire nrst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire general_pin_zero,
  input wire general_pin_two,
  input wire frame_clk,
  output wire dsp_clk_out,
  output wire dac_clk_out,
  output wire pump_clk_out,
  output wire oversample_clk_out,
  output wire pll_ref_out,
  output reg clocks_halt_r,
  output reg dac_active_r
);
  localparam ST_RUN = 2'd0;
  localparam ST_HALT = 2'd1;
  localparam ST_ALIGN = 2'd2;

  // register file
  reg [7:0] dsp_dac_gpio_clock_select_r;
  reg [7:0] pump_oversample_gpio_clock_select_r;
  reg [7:0] pll_reference_gpio_select_r;
  reg [7:0] clock_resync_control_r;
  reg [16:0] source_ctrl_r;
  reg [7:0] dsp_dac_nxt;
  reg [7:0] pump_osr_nxt;
  reg [7:0] pll_ref_nxt;
  reg [7:0] resync_nxt;
  reg [16:0] source_nxt;

  // bus data phase
  reg wr_pend_r;
  reg [9:0] wr_addr_r;
  wire addr_phase;
  wire wr_now;

  // resync control
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg standby_prev_r;
  reg frame_prev_r;
  reg clocks_halt_nxt;
  reg dac_active_nxt;
  wire [2:0] pins_q;
  wire frame_q;
  wire frame_start;
  wire standby;
  wire leave_standby;
  wire auto_resync_enable;
  wire resync_request;

  // mux inputs per channel: dsp, dac, pump, oversample, pll reference
  wire [4:0] gpio_is_source;
  wire [14:0] pin_codes;
  wire [4:0] mux_out;
  wire [2:0] dsp_clock_pin_select;
  wire [2:0] dac_clock_pin_select;
  wire [2:0] pump_clock_pin_select;
  wire [2:0] oversample_clock_pin_select;
  wire [2:0] pll_ref_pin_select;
  wire [2:0] dsp_divider_source;
  wire [2:0] dac_divider_source;
  wire [2:0] pll_reference_source;
  wire [31:0] status_word;
  reg [31:0] rd_nxt;
  genvar ch;

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & htrans[1] & hready;
  assign wr_now = wr_pend_r;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 10'h000;
    end else if (hready) begin
      // writes outside the decoded window are dropped, as reads return zero there
      wr_pend_r <= addr_phase & hwrite & (haddr[31:10] == 22'h000000);
      wr_addr_r <= haddr[9:0];
    end
  end

  // next values merge a write landing this cycle
  always @* begin
    dsp_dac_nxt = dsp_dac_gpio_clock_select_r;
    pump_osr_nxt = pump_oversample_gpio_clock_select_r;
    pll_ref_nxt = pll_reference_gpio_select_r;
    resync_nxt = clock_resync_control_r;
    source_nxt = source_ctrl_r;
    if (wr_now) begin
      case (wr_addr_r)
        `ADDR_DSP_DAC_SEL: dsp_dac_nxt = hwdata[7:0];
        `ADDR_PUMP_OSR_SEL: pump_osr_nxt = hwdata[7:0];
        `ADDR_PLL_REF_SEL: pll_ref_nxt = hwdata[7:0];
        `ADDR_RESYNC_CTRL: resync_nxt = hwdata[7:0];
        `ADDR_SOURCE_CTRL: source_nxt = hwdata[16:0];
        default: source_nxt = source_ctrl_r;
      endcase
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dsp_dac_gpio_clock_select_r <= `RST_DSP_DAC_SEL;
      pump_oversample_gpio_clock_select_r <= `RST_PUMP_OSR_SEL;
      pll_reference_gpio_select_r <= `RST_PLL_REF_SEL;
      clock_resync_control_r <= `RST_RESYNC_CTRL;
      source_ctrl_r <= `RST_SOURCE_CTRL;
    end else begin
      dsp_dac_gpio_clock_select_r <= dsp_dac_nxt;
      pump_oversample_gpio_clock_select_r <= pump_osr_nxt;
      pll_reference_gpio_select_r <= pll_ref_nxt;
      clock_resync_control_r <= resync_nxt;
      source_ctrl_r <= source_nxt;
    end
  end

  // read data taken from next values so a write just before a read is seen
  assign status_word = {26'h0000000, standby, frame_q, dac_active_r,
    clocks_halt_r, state_r};

  always @* begin
    rd_nxt = 32'h00000000;
    case (haddr[9:0])
      `ADDR_DSP_DAC_SEL: rd_nxt = {24'h000000, dsp_dac_nxt};
      `ADDR_PUMP_OSR_SEL: rd_nxt = {24'h000000, pump_osr_nxt};
      `ADDR_PLL_REF_SEL: rd_nxt = {24'h000000, pll_ref_nxt};
      `ADDR_RESYNC_CTRL: rd_nxt = {24'h000000, resync_nxt};
      `ADDR_SOURCE_CTRL: rd_nxt = {15'h0000, source_nxt};
      `ADDR_STATUS: rd_nxt = status_word;
      default: rd_nxt = 32'h00000000;
    endcase
    if (haddr[31:10] != 22'h000000) begin
      rd_nxt = 32'h00000000;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase & ~hwrite) begin
      hrdata <= rd_nxt;
    end
  end

  // field views
  assign dsp_clock_pin_select = dsp_dac_gpio_clock_select_r[`HI_PIN_LSB+2:`HI_PIN_LSB];
  assign dac_clock_pin_select = dsp_dac_gpio_clock_select_r[`LO_PIN_LSB+2:`LO_PIN_LSB];
  assign pump_clock_pin_select =
    pump_oversample_gpio_clock_select_r[`HI_PIN_LSB+2:`HI_PIN_LSB];
  assign oversample_clock_pin_select =
    pump_oversample_gpio_clock_select_r[`LO_PIN_LSB+2:`LO_PIN_LSB];
  assign pll_ref_pin_select = pll_reference_gpio_select_r[`LO_PIN_LSB+2:`LO_PIN_LSB];
  assign dsp_divider_source = source_ctrl_r[`SRC_DSP_LSB+2:`SRC_DSP_LSB];
  assign dac_divider_source = source_ctrl_r[`SRC_DAC_LSB+2:`SRC_DAC_LSB];
  assign pll_reference_source = source_ctrl_r[`SRC_PLL_LSB+2:`SRC_PLL_LSB];
  assign standby = source_ctrl_r[`SRC_STANDBY_BIT];
  assign auto_resync_enable = clock_resync_control_r[`AUTO_RESYNC_BIT];
  assign resync_request = clock_resync_control_r[`RESYNC_REQ_BIT];

  assign gpio_is_source[0] = (dsp_divider_source == `DIV_SRC_GPIO);
  assign gpio_is_source[1] = (dac_divider_source == `DIV_SRC_GPIO);
  assign gpio_is_source[2] = source_ctrl_r[`SRC_PUMP_GPIO_BIT];
  assign gpio_is_source[3] = source_ctrl_r[`SRC_OSR_GPIO_BIT];
  assign gpio_is_source[4] = (pll_reference_source == `PLL_SRC_GPIO);
  assign pin_codes = {pll_ref_pin_select, oversample_clock_pin_select,
    pump_clock_pin_select, dac_clock_pin_select, dsp_clock_pin_select};

  // pins and frame clock are foreign to mclk, so they are sampled;
  // this limits usable pin clocks to well under half of mclk
  pin_sync #(
    .W(3)
  ) u_pin_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin_in({frame_clk, general_pin_two, general_pin_zero}),
    .pin_q(pins_q)
  );
  assign frame_q = pins_q[2];

  generate
    for (ch = 0; ch < 5; ch = ch + 1) begin : g_mux
      clk_pin_mux u_mux (
        .mclk(mclk),
        .nrst(nrst),
        .gpio_is_source(gpio_is_source[ch]),
        .pin_code(pin_codes[3*ch+2:3*ch]),
        .pin_zero(pins_q[0]),
        .pin_two(pins_q[1]),
        .clk_out(mux_out[ch])
      );
    end
  endgenerate

  assign dsp_clk_out = mux_out[0];
  assign dac_clk_out = mux_out[1] & ~clocks_halt_r;
  assign pump_clk_out = mux_out[2] & ~clocks_halt_r;
  assign oversample_clk_out = mux_out[3] & ~clocks_halt_r;
  assign pll_ref_out = mux_out[4];

  // frame start and standby edge
  assign frame_start = frame_q & ~frame_prev_r;
  assign leave_standby = standby_prev_r & ~standby;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frame_prev_r <= 1'b0;
      standby_prev_r <= 1'b1;
    end else begin
      frame_prev_r <= frame_q;
      standby_prev_r <= standby;
    end
  end

  // resync sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (resync_request) begin
          state_nxt = ST_HALT;
        end else if (leave_standby & auto_resync_enable) begin
          state_nxt = ST_ALIGN;
        end
      end
      ST_HALT: begin
        if (!resync_request) begin
          state_nxt = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        if (resync_request) begin
          state_nxt = ST_HALT;
        end else if (frame_start) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  // the halt gates the dac, pump and oversample clock outputs low
  always @* begin
    clocks_halt_nxt = (state_nxt != ST_RUN);
  end

  // dac waits in standby until the auto realignment lands on a frame
  always @* begin
    dac_active_nxt = dac_active_r;
    if (standby) begin
      dac_active_nxt = 1'b0;
    end else if (state_nxt == ST_RUN && state_r != ST_HALT) begin
      dac_active_nxt = 1'b1;
    end
    if (leave_standby & auto_resync_enable & ~resync_request) begin
      dac_active_nxt = 1'b0;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_RUN;
      clocks_halt_r <= 1'b0;
      dac_active_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      clocks_halt_r <= clocks_halt_nxt;
      dac_active_r <= dac_active_nxt;
    end
  end

  wire unused_bus;
  assign unused_bus = ^{hsize, hwdata[31:17]};
endmodule // gpio_clock_select_and_resync
`default_nettype wire

// ===== hw/clk_sel_consts.vh
`ifndef CLK_SEL_CONSTS_VH
`define CLK_SEL_CONSTS_VH
// register indexes and byte addresses
`define IDX_DSP_DAC_SEL 8'h10
`define IDX_PUMP_OSR_SEL 8'h11
`define IDX_PLL_REF_SEL 8'h12
`define IDX_RESYNC_CTRL 8'h13
`define IDX_SOURCE_CTRL 8'h20
`define IDX_STATUS 8'h21
`define ADDR_DSP_DAC_SEL 10'h040
`define ADDR_PUMP_OSR_SEL 10'h044
`define ADDR_PLL_REF_SEL 10'h048
`define ADDR_RESYNC_CTRL 10'h04C
`define ADDR_SOURCE_CTRL 10'h080
`define ADDR_STATUS 10'h084
// reset values
`define RST_DSP_DAC_SEL 8'h00
`define RST_PUMP_OSR_SEL 8'h00
`define RST_PLL_REF_SEL 8'h00
`define RST_RESYNC_CTRL 8'h10
`define RST_SOURCE_CTRL 17'h10000
// field positions
`define HI_PIN_LSB 4
`define LO_PIN_LSB 0
`define AUTO_RESYNC_BIT 4
`define RESYNC_REQ_BIT 0
`define SRC_DSP_LSB 0
`define SRC_DAC_LSB 4
`define SRC_PLL_LSB 8
`define SRC_PUMP_GPIO_BIT 12
`define SRC_OSR_GPIO_BIT 13
`define SRC_STANDBY_BIT 16
// codes
`define PIN_CODE_ZERO 3'h3
`define PIN_CODE_TWO 3'h5
`define DIV_SRC_GPIO 3'h5
`define PLL_SRC_GPIO 3'h3
`endif

// ===== hw/pin_sync.v
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter W = 3
) (
  input wire mclk,
  input wire nrst,
  input wire [W-1:0] pin_in,
  output reg [W-1:0] pin_q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar i;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // a bit changes only once the last two stages agree
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          pin_q[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          pin_q[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule // pin_sync
`default_nettype wire

// ===== hw/clk_pin_mux.v
`timescale 1ns/1ps
`include "clk_sel_consts.vh"
`default_nettype none
module clk_pin_mux (
  input wire mclk,
  input wire nrst,
  input wire gpio_is_source,
  input wire [2:0] pin_code,
  input wire pin_zero,
  input wire pin_two,
  output reg clk_out
);
  reg clk_nxt;
  always @* begin
    clk_nxt = 1'b0;
    if (gpio_is_source) begin
      case (pin_code)
        `PIN_CODE_ZERO: clk_nxt = pin_zero;
        `PIN_CODE_TWO: clk_nxt = pin_two;
        default: clk_nxt = 1'b0;
      endcase
    end
  end
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_out <= 1'b0;
    end else begin
      clk_out <= clk_nxt;
    end
  end
endmodule // clk_pin_mux
`default_nettype wire

// ===== bench/clk_sel_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module clk_sel_monitor (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic general_pin_zero,
  input wire logic general_pin_two,
  input wire logic frame_clk,
  input wire logic dsp_clk_out,
  input wire logic dac_clk_out,
  input wire logic pump_clk_out,
  input wire logic oversample_clk_out,
  input wire logic pll_ref_out,
  input wire logic clocks_halt_r,
  input wire logic dac_active_r
);
  logic rd_unm_r, wr_rs_r, f1, f2, f3;
  logic [3:0] frm_age, low_cnt;
  // own frame sync runs two stages short, so age at release stays small
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {rd_unm_r, wr_rs_r, f1, f2, f3, frm_age, low_cnt} <= {5'h0, 4'hF, 4'h0};
    end else begin
      rd_unm_r <= hsel && htrans[1] && hready && !hwrite && (haddr[31:10] != 22'h0);
      wr_rs_r <= hsel && htrans[1] && hready && hwrite && (haddr == 32'h0000004C);
      {f3, f2, f1} <= {f2, f1, frame_clk};
      frm_age <= (f2 && !f3) ? 4'h0 : frm_age + {3'h0, frm_age != 4'hF};
      low_cnt <= (general_pin_zero || general_pin_two) ? 4'h0 : low_cnt + {3'h0, low_cnt != 4'hF};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  halt_mutes_a: assert property (clocks_halt_r |->
    !(dac_clk_out || pump_clk_out || oversample_clk_out)) else $error("clock runs while halted");
  req_halts_a: assert property (wr_rs_r && hwdata[0] |-> ##[1:3] clocks_halt_r)
    else $error("request did not halt");
  frame_release_a: assert property ($fell(clocks_halt_r) |-> frm_age <= 4'h6)
    else $error("release not aligned to frame");
  active_aligned_a: assert property ($rose(dac_active_r) |-> !clocks_halt_r)
    else $error("dac active while halted");
  pins_mute_a: assert property (low_cnt >= 4'h8 |->
    !(dsp_clk_out || dac_clk_out || pump_clk_out || oversample_clk_out || pll_ref_out))
    else $error("clock without pin activity");
  unmapped_zero_a: assert property (rd_unm_r |-> hrdata == 32'h0) else $error("unmapped read");
  okay_resp_a: assert property (!hresp) else $error("error response");
  never_wait_a: assert property (hreadyout) else $error("wait state");
endmodule // clk_sel_monitor
bind gpio_clock_select_and_resync clk_sel_monitor i_clk_sel_monitor (.mclk(mclk), .nrst(nrst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .general_pin_zero(general_pin_zero), .general_pin_two(general_pin_two), .frame_clk(frame_clk),
  .dsp_clk_out(dsp_clk_out), .dac_clk_out(dac_clk_out), .pump_clk_out(pump_clk_out),
  .oversample_clk_out(oversample_clk_out), .pll_ref_out(pll_ref_out),
  .clocks_halt_r(clocks_halt_r), .dac_active_r(dac_active_r));
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, nrst, hsel, hwrite, p0, p2, frame_clk, rd_dp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, r;
  wire logic hreadyout, hresp, dsp, dac, pump, osr, pll, halt, act;
  wire logic [31:0] hrdata;
  wire logic [6:0] ov = {dsp, dac, pump, osr, pll, halt, act};
  logic [31:0] exp_q[$];
  logic [6:0] ck_q[$];
  event ck_ev;
  integer seed, bad_count, n_tests, i, c, pass;
  gpio_clock_select_and_resync i_gpio_clock_select_and_resync (.mclk(mclk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .general_pin_zero(p0), .general_pin_two(p2), .frame_clk(frame_clk), .dsp_clk_out(dsp),
    .dac_clk_out(dac), .pump_clk_out(pump), .oversample_clk_out(osr), .pll_ref_out(pll),
    .clocks_halt_r(halt), .dac_active_r(act));
  function automatic logic f(input integer k);
    f = (k == 3) ? p0 : (k == 5) ? p2 : 1'h0;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests = n_tests + 1;
    if (got !== want) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
      bad_count = bad_count + 1;
    end
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task die;
    bad_count = bad_count + 1;
    summarize;
  endtask
  task hs;
    integer k;
    k = 0;
    do begin
      @(posedge mclk);
      k = k + 1;
    end while (hreadyout !== 1'h1 && k < 50);
    if (hreadyout !== 1'h1) die;
  endtask
  // reads note their expected word; write data phase never sees a stale value
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    {hsel, htrans, hwrite, haddr} <= {1'h1, 2'h2, w, a};
    hs;
    {hsel, htrans, hwdata} <= {1'h0, 2'h0, w ? d : ~d};
    hs;
  endtask
  task snap(input logic [6:0] e);
    #1;
    ck_q.push_back(e);
    -> ck_ev;
    @(posedge mclk);
  endtask
  task wt(input logic k);
    integer j;
    j = 0;
    while ((k ? act : !halt) !== 1'h1 && j < 300) begin
      @(negedge mclk);
      j = j + 1;
    end
    if (j >= 300) die;
    @(posedge mclk);
  endtask
  always #20 mclk = !mclk;
  always begin
    repeat (20) @(posedge mclk);
    frame_clk <= !frame_clk;
  end
  always @(posedge mclk) begin
    if (rd_dp && exp_q.size() > 0) chk(hrdata, exp_q.pop_front());
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  always @(ck_ev) chk({25'h0, ov}, ck_q.pop_front());
  initial begin
    repeat (20000) @(posedge mclk);
    die;
  end
  initial begin
    seed = 75;
    bad_count = 0;
    n_tests = 0;
    {mclk, nrst, hsel, hwrite, p0, p2, frame_clk, rd_dp, htrans, haddr, hwdata} = '0;
    repeat (6) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
    for (i = 0; i < 4; i++) bus(1'h0, 32'h40 + 4 * i, (i == 3) ? 32'h10 : 32'h0);
    for (i = 0; i < 3; i++) begin
      r = $random(seed) & 32'hFF;
      bus(1'h1, 32'h40 + 4 * i, r);
      bus(1'h0, 32'h40 + 4 * i, r);
    end
    bus(1'h0, 32'h400, 32'h0);
    bus(1'h0, 32'h10000048, 32'h0);
    bus(1'h1, 32'h10000048, 32'hFF);
    bus(1'h0, 32'h48, r);
    $display("test registers done");
    bus(1'h1, 32'h80, 32'h13355);
    bus(1'h0, 32'h80, 32'h13355);
    snap(7'h00);
    bus(1'h1, 32'h80, 32'h03355);
    wt(1'h1);
    snap(7'h01);
    $display("test auto resync done");
    for (pass = 0; pass < 2; pass++) begin
      for (c = 0; c < 8; c++) begin
        {p0, p2} <= {pass == 0, pass == 1};
        bus(1'h1, 32'h40, {25'h0, c[2:0], 1'h0, ~c[2:0]});
        bus(1'h1, 32'h44, {25'h0, c[2:0], 1'h0, ~c[2:0]});
        bus(1'h1, 32'h48, {29'h0, ~c[2:0]});
        repeat (8) @(posedge mclk);
        snap({f(c), f(7 - c), f(c), f(7 - c), f(7 - c), 2'h1});
      end
    end
    $display("test pin select done");
    bus(1'h1, 32'h40, 32'h55);
    bus(1'h1, 32'h44, 32'h55);
    bus(1'h1, 32'h48, 32'h05);
    repeat (8) @(posedge mclk);
    snap(7'h7D);
    bus(1'h1, 32'h4C, 32'h11);
    repeat (3) @(posedge mclk);
    snap(7'h47);
    bus(1'h0, 32'h4C, 32'h11);
    bus(1'h1, 32'h4C, 32'h10);
    wt(1'h0);
    snap(7'h7D);
    $display("test manual resync done");
    // without auto realignment the dac must wake at once, not wait for a frame
    bus(1'h1, 32'h80, 32'h13355);
    bus(1'h1, 32'h4C, 32'h00);
    bus(1'h1, 32'h80, 32'h03355);
    repeat (2) @(posedge mclk);
    snap(7'h7D);
    $display("test auto disabled done");
    summarize;
  end
endmodule // tb_top
`default_nettype wire
